// ---- rtl/mdma_controller.sv ----
`include "mdma_defines.svh"
`default_nettype none
// Functional notes
// - six channels, each with its own independent transfer context
// - address map ignores memory-mode, rom-in-data and overlay bits
// - per-channel priority bit; equal-level requests served round-robin
// - source and destination separately keep, increment, decrement or index
// - autoinitialize_enable reloads addresses and counts at block end and continues
// - reload select 0 uses channel zero set, 1 per-channel sets
// - 8-bit frame counter decrements on last read of frame; 0 is one frame
// - after last frame with autoinitialize_enable, frame count reloaded from reload set
// - 16-bit element counter decrements after each element read
// - autoinitialize_enable reloads element count after last frame
// - doubleword element moves as two 16-bit transfers, address update each
// - index selects pick one of two element and two frame indexes
// - non-last transfers add selected element index
// - last transfer of frame adds selected frame index
// - interrupt enable low means no channel interrupt at all
// - autobuffer mode: full only, or half and full when mode bit set
// - multiframe: block end only, or each frame end when mode bit set
// - 4-bit sync select: none, timer, external interrupt three, reserved
// - codes 1-6 serial port events, 7-12 same in bit-serial buffered mode
// - each channel raises own interrupt; channels 0-3 share serial lines
// - interrupt line select routes lines 6, 7, 10, 11
module mdma_controller
  import mdma_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [5:0]            channelEnable,
  input  wire logic [5:0]            channelPriority,
  input  wire logic [5:0]            autoinitializeEnable,
  input  wire logic [5:0]            doublewordMode,
  input  wire logic [5:0]            autobufferingMode,
  input  wire logic [5:0]            interruptEnableBit,
  input  wire logic [5:0]            interruptMode,
  input  wire logic [11:0]           sourceModify,
  input  wire logic [11:0]           destinationModify,
  input  wire logic [5:0]            sourceIndexSelect,
  input  wire logic [5:0]            destinationIndexSelect,
  input  wire logic [23:0]           syncEventSelect,
  input  wire logic                  perChannelReloadSelect,
  input  wire logic [1:0]            interruptLineSelect,
  input  wire logic                  processorMemoryMode,
  input  wire logic                  romInDataSpace,
  input  wire logic                  ramOverlay,
  input  wire logic                  cfgWrite,
  input  wire logic [2:0]            cfgChannel,
  input  wire logic [15:0]           cfgSourceAddress,
  input  wire logic [15:0]           cfgDestinationAddress,
  input  wire logic [15:0]           cfgElementCount,
  input  wire logic [7:0]            cfgFrameCount,
  input  wire logic                  reloadWrite,
  input  wire logic [2:0]            reloadChannel,
  input  wire logic [15:0]           reloadSourceAddress,
  input  wire logic [15:0]           reloadDestinationAddress,
  input  wire logic [15:0]           reloadElementCount,
  input  wire logic [7:0]            reloadFrameCount,
  input  wire logic [15:0]           elementIndexZero,
  input  wire logic [15:0]           elementIndexOne,
  input  wire logic [15:0]           frameIndexZero,
  input  wire logic [15:0]           frameIndexOne,
  input  wire logic [5:0]            serialEvent,
  input  wire logic [5:0]            bitSerialEvent,
  input  wire logic                  timerEvent,
  input  wire logic                  externalInterruptThree,
  input  wire logic [3:0]            serialPortInterrupt,
  input  wire logic [15:0]           memReadData,
  output logic                       memRead,
  output logic                       memWrite,
  output logic [15:0]                memAddress,
  output logic [15:0]                memWriteData,
  output logic [5:0]                 channelBusy,
  output logic [5:0]                 channelInterrupt,
  output logic [3:0]                 sharedInterruptLine,
  output logic                       channel4Interrupt,
  output logic                       channel5Interrupt
);
  // per-channel context, flip-flop arrays indexed by channel
  logic [15:0] srcQ     [6];
  logic [15:0] dstQ     [6];
  logic [15:0] elemQ    [6];
  logic [7:0]  frameQ   [6];
  logic [15:0] elemInitQ[6];
  logic [15:0] gSrcQ    [6];
  logic [15:0] gDstQ    [6];
  logic [15:0] gElemQ   [6];
  logic [7:0]  gFrameQ  [6];
  logic [5:0]  activeQ;
  logic [5:0]  pendQ;
  logic [5:0]  extPrevQ;
  logic [5:0]  halfDoneQ;

  mdma_state_t stateQ;
  logic [2:0]  curQ;
  logic        halfQ;
  logic [5:0]  grant;
  logic [5:0]  request;
  logic [2:0]  grantIdx;
  logic        memReadQ;
  logic        memWriteQ;
  logic [15:0] memAddrQ;
  logic [15:0] memDataQ;
  logic [5:0]  irqPulseQ;
  logic [3:0]  sharedQ;
  logic        ch4Q;
  logic        ch5Q;

  // address decode deliberately ignores the map configuration inputs
  logic unusedMapBits;
  assign unusedMapBits = processorMemoryMode ^ romInDataSpace ^ ramOverlay;

  function automatic logic [2:0] onehot_idx(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 0; k < 6; k++) begin
      if (v[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction : onehot_idx

  // next address after one 16-bit transfer
  function automatic logic [15:0] next_addr(input logic [15:0] a, input logic [1:0] m,
                                            input logic [15:0] idx);
    logic [15:0] r;
    case (m)
      `MDMA_MOD_KEEP:  r = a;
      `MDMA_MOD_INC:   r = a + 16'h0001;
      `MDMA_MOD_DEC:   r = a - 16'h0001;
      `MDMA_MOD_INDEX: r = a + idx;
      default:         r = a;
    endcase
    return r;
  endfunction : next_addr

  // sync event selection per channel
  function automatic logic sync_hit(input logic [3:0] s, input logic [5:0] se, input logic [5:0] bse,
                                    input logic tmr, input logic ext);
    logic r;
    r = 1'b0;
    if (s >= `MDMA_SYNC_SP_LO && s <= `MDMA_SYNC_SP_HI) begin
      r = se[3'(s - `MDMA_SYNC_SP_LO)];
    end else if (s >= `MDMA_SYNC_BS_LO && s <= `MDMA_SYNC_BS_HI) begin
      r = bse[3'(s - `MDMA_SYNC_BS_LO)];
    end else if (s == `MDMA_SYNC_TIMER) begin
      r = tmr;
    end else if (s == `MDMA_SYNC_EXT3) begin
      r = ext;
    end
    return r;
  endfunction : sync_hit

  generate
    for (genvar c = 0; c < 6; c++) begin : g_sync
      logic hit;
      logic [3:0] sel;
      assign sel = syncEventSelect[4*c +: 4];
      assign hit = (sel == `MDMA_SYNC_EXT3) ? (externalInterruptThree & ~extPrevQ[c])
                 : sync_hit(sel, serialEvent, bitSerialEvent, timerEvent, 1'b0);
      // unsynchronized channels request continuously; reserved code never fires
      assign request[c] = activeQ[c] & channelEnable[c] &
                          ((sel == `MDMA_SYNC_NONE) | pendQ[c]);

      always_ff @(posedge clk) begin
        if (rst) begin
          pendQ[c]    <= 1'b0;
          extPrevQ[c] <= 1'b0;
        end else begin
          extPrevQ[c] <= externalInterruptThree;
          if (hit) begin
            pendQ[c] <= 1'b1; // event beats the clear below
          end else if (stateQ == MDMA_UPD && curQ == 3'(c) && !(doublewordMode[c] && !halfQ)) begin
            pendQ[c] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  mdma_arbiter u_arb (
    .clk     (clk),
    .rst     (rst),
    .req     (request),
    .highPri (channelPriority),
    .advance (stateQ == MDMA_IDLE && request != 6'h00),
    .grant   (grant)
  );
  assign grantIdx = onehot_idx(grant);

  // element-level flags of the current channel
  logic        lastElem;
  logic        lastFrame;
  logic        elemDone;
  logic [15:0] srcElemIdx;
  logic [15:0] dstElemIdx;
  logic [15:0] srcIdx;
  logic [15:0] dstIdx;
  logic [2:0]  rsel;
  assign lastElem  = (elemQ[curQ] == 16'h0000);
  assign lastFrame = (frameQ[curQ] == 8'h00);
  assign elemDone  = !doublewordMode[curQ] || halfQ;
  assign srcElemIdx = sourceIndexSelect[curQ] ? elementIndexOne : elementIndexZero;
  assign dstElemIdx = destinationIndexSelect[curQ] ? elementIndexOne : elementIndexZero;
  assign srcIdx = (lastElem && elemDone) ? (sourceIndexSelect[curQ] ? frameIndexOne : frameIndexZero)
                : srcElemIdx;
  assign dstIdx = (lastElem && elemDone) ? (destinationIndexSelect[curQ] ? frameIndexOne : frameIndexZero)
                : dstElemIdx;
  assign rsel = perChannelReloadSelect ? curQ : 3'h0;

  // transfer sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      stateQ    <= MDMA_IDLE;
      curQ      <= 3'h0;
      halfQ     <= 1'b0;
      memReadQ  <= 1'b0;
      memWriteQ <= 1'b0;
      memAddrQ  <= 16'h0000;
      memDataQ  <= 16'h0000;
    end else begin
      memReadQ  <= 1'b0;
      memWriteQ <= 1'b0;
      case (stateQ)
        MDMA_IDLE: begin
          if (request != 6'h00) begin
            curQ     <= grantIdx;
            halfQ    <= 1'b0;
            memReadQ <= 1'b1;
            memAddrQ <= srcQ[grantIdx];
            stateQ   <= MDMA_READ;
          end
        end
        MDMA_READ: begin
          stateQ <= MDMA_WRITE;
        end
        MDMA_WRITE: begin
          memWriteQ <= 1'b1;
          memAddrQ  <= dstQ[curQ];
          memDataQ  <= memReadData;
          stateQ    <= MDMA_UPD;
        end
        MDMA_UPD: begin
          if (!elemDone) begin
            halfQ    <= 1'b1; // second half of doubleword follows at once
            memReadQ <= 1'b1;
            memAddrQ <= next_addr(srcQ[curQ], sourceModify[2*curQ +: 2], srcIdx);
            stateQ   <= MDMA_READ;
          end else begin
            stateQ <= MDMA_IDLE;
          end
        end
        default: stateQ <= MDMA_IDLE;
      endcase
    end
  end

  // reload register sets, written by software at any time
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < 6; k++) begin
        gSrcQ[k]   <= 16'h0000;
        gDstQ[k]   <= 16'h0000;
        gElemQ[k]  <= 16'h0000;
        gFrameQ[k] <= 8'h00;
      end
    end else if (reloadWrite && reloadChannel < 3'h6) begin
      gSrcQ[reloadChannel]   <= reloadSourceAddress;
      gDstQ[reloadChannel]   <= reloadDestinationAddress;
      gElemQ[reloadChannel]  <= reloadElementCount;
      gFrameQ[reloadChannel] <= reloadFrameCount;
    end
  end

  // channel context update
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < 6; k++) begin
        srcQ[k]      <= 16'h0000;
        dstQ[k]      <= 16'h0000;
        elemQ[k]     <= 16'h0000;
        elemInitQ[k] <= 16'h0000;
        frameQ[k]    <= 8'h00;
      end
      activeQ <= 6'h00;
    end else begin
      if (cfgWrite && cfgChannel < 3'h6) begin
        srcQ[cfgChannel]      <= cfgSourceAddress;
        dstQ[cfgChannel]      <= cfgDestinationAddress;
        elemQ[cfgChannel]     <= cfgElementCount;
        elemInitQ[cfgChannel] <= cfgElementCount;
        frameQ[cfgChannel]    <= cfgFrameCount;
        activeQ[cfgChannel]   <= 1'b1;
      end
      if (stateQ == MDMA_UPD) begin
        srcQ[curQ] <= next_addr(srcQ[curQ], sourceModify[2*curQ +: 2], srcIdx);
        dstQ[curQ] <= next_addr(dstQ[curQ], destinationModify[2*curQ +: 2], dstIdx);
        if (elemDone) begin
          if (!lastElem) begin
            elemQ[curQ] <= elemQ[curQ] - 16'h0001;
          end else if (!lastFrame) begin
            frameQ[curQ] <= frameQ[curQ] - 8'h01;
            elemQ[curQ]  <= elemInitQ[curQ];
          end else if (autoinitializeEnable[curQ]) begin
            // reload contents used only here, at the block boundary
            srcQ[curQ]      <= gSrcQ[rsel];
            dstQ[curQ]      <= gDstQ[rsel];
            elemQ[curQ]     <= gElemQ[rsel];
            elemInitQ[curQ] <= gElemQ[rsel];
            frameQ[curQ]    <= gFrameQ[rsel];
          end else begin
            activeQ[curQ] <= 1'b0;
          end
        end
      end
    end
  end

  // interrupt events
  logic frameEnd;
  logic blockEnd;
  logic halfPoint;
  assign frameEnd  = stateQ == MDMA_UPD && elemDone && lastElem;
  assign blockEnd  = frameEnd && lastFrame;
  // half buffer: element count crosses half of its frame start value
  assign halfPoint = stateQ == MDMA_UPD && elemDone && !lastElem &&
                     (elemQ[curQ] == {1'b0, elemInitQ[curQ][15:1]}) && !halfDoneQ[curQ];

  always_ff @(posedge clk) begin
    if (rst) begin
      irqPulseQ <= 6'h00;
      halfDoneQ <= 6'h00;
    end else begin
      irqPulseQ <= 6'h00;
      if (halfPoint) begin
        halfDoneQ[curQ] <= 1'b1;
      end else if (blockEnd) begin
        halfDoneQ[curQ] <= 1'b0;
      end
      if (interruptEnableBit[curQ]) begin
        if (autobufferingMode[curQ]) begin
          irqPulseQ[curQ] <= blockEnd || (interruptMode[curQ] && halfPoint);
        end else begin
          irqPulseQ[curQ] <= interruptMode[curQ] ? frameEnd : blockEnd;
        end
      end
    end
  end

  // line routing; reserved select keeps serial sources
  always_ff @(posedge clk) begin
    if (rst) begin
      sharedQ <= 4'h0;
      ch4Q    <= 1'b0;
      ch5Q    <= 1'b0;
    end else begin
      ch4Q <= irqPulseQ[4];
      ch5Q <= irqPulseQ[5];
      case (interruptLineSelect)
        `MDMA_ISEL_HALF: sharedQ <= {irqPulseQ[3], irqPulseQ[2], serialPortInterrupt[1:0]};
        `MDMA_ISEL_ALL:  sharedQ <= irqPulseQ[3:0];
        default:         sharedQ <= serialPortInterrupt;
      endcase
    end
  end

  assign memRead             = memReadQ;
  assign memWrite            = memWriteQ;
  assign memAddress          = memAddrQ;
  assign memWriteData        = memDataQ;
  assign channelBusy         = activeQ;
  assign channelInterrupt    = irqPulseQ;
  assign sharedInterruptLine = sharedQ;
  assign channel4Interrupt   = ch4Q;
  assign channel5Interrupt   = ch5Q;

  chk_no_irq_disabled: assert property (@(posedge clk) disable iff (rst)
    (stateQ == MDMA_UPD && !interruptEnableBit[curQ]) |=> !irqPulseQ[$past(curQ)])
    else $error("interrupt while disabled");
  chk_block_irq: assert property (@(posedge clk) disable iff (rst)
    (blockEnd && interruptEnableBit[curQ]) |=> irqPulseQ[$past(curQ)])
    else $error("block end interrupt missing");
  chk_elem_decr: assert property (@(posedge clk) disable iff (rst)
    (stateQ == MDMA_UPD && elemDone && !lastElem && !cfgWrite) |=>
      elemQ[$past(curQ)] == $past(elemQ[curQ]) - 16'h0001)
    else $error("element count not decremented");
  chk_read_write: assert property (@(posedge clk) disable iff (rst)
    memRead |-> ##2 memWrite)
    else $error("write does not follow read");
  chk_high_first: assert property (@(posedge clk) disable iff (rst)
    (stateQ == MDMA_IDLE && (request & channelPriority) != 6'h00) |=> channelPriority[curQ])
    else $error("low priority granted over high");
  chk_route_all: assert property (@(posedge clk) disable iff (rst)
    (interruptLineSelect == `MDMA_ISEL_ALL) |=> sharedInterruptLine == $past(irqPulseQ[3:0]))
    else $error("shared line routing wrong");
  chk_route_ser: assert property (@(posedge clk) disable iff (rst)
    (interruptLineSelect == `MDMA_ISEL_SERIAL) |=> sharedInterruptLine == $past(serialPortInterrupt))
    else $error("serial routing wrong");
  chk_frame_decr: assert property (@(posedge clk) disable iff (rst)
    (frameEnd && !lastFrame && !cfgWrite) |=> frameQ[$past(curQ)] == $past(frameQ[curQ]) - 8'h01)
    else $error("frame count not decremented");
endmodule : mdma_controller
`default_nettype wire

// ---- rtl/mdma_defines.svh ----
`ifndef MDMA_DEFINES_SVH
`define MDMA_DEFINES_SVH
`define MDMA_NCH          6
`define MDMA_AW           16
`define MDMA_SYNC_NONE    4'h0
`define MDMA_SYNC_SP_LO   4'h1
`define MDMA_SYNC_SP_HI   4'h6
`define MDMA_SYNC_BS_LO   4'h7
`define MDMA_SYNC_BS_HI   4'hC
`define MDMA_SYNC_TIMER   4'hD
`define MDMA_SYNC_EXT3    4'hE
`define MDMA_ISEL_SERIAL  2'h0
`define MDMA_ISEL_HALF    2'h1
`define MDMA_ISEL_ALL     2'h2
`define MDMA_MOD_KEEP     2'h0
`define MDMA_MOD_INC      2'h1
`define MDMA_MOD_DEC      2'h2
`define MDMA_MOD_INDEX    2'h3
`endif

// ---- rtl/mdma_pkg.sv ----
`default_nettype none
package mdma_pkg;
  typedef enum logic [3:0] {
    MDMA_IDLE  = 4'h1,
    MDMA_READ  = 4'h2,
    MDMA_WRITE = 4'h4,
    MDMA_UPD   = 4'h8
  } mdma_state_t;
endpackage : mdma_pkg
`default_nettype wire

// ---- rtl/mdma_arbiter.sv ----
`include "mdma_defines.svh"
`default_nettype none
module mdma_arbiter
  import mdma_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [5:0] req,
  input  wire logic [5:0] highPri,
  input  wire logic       advance,
  output logic [5:0]      grant
);
  logic [2:0] lastQ;

  // rotate from the channel after the last winner
  function automatic logic [5:0] rr_pick(input logic [5:0] r, input logic [2:0] last);
    logic [5:0] g;
    logic [2:0] idx;
    g = 6'h00;
    for (int k = 1; k <= 6; k++) begin
      idx = 3'((int'(last) + k) % 6);
      if (g == 6'h00 && r[idx]) begin
        g[idx] = 1'b1;
      end
    end
    return g;
  endfunction : rr_pick

  always_comb begin
    if ((req & highPri) != 6'h00) begin
      grant = rr_pick(req & highPri, lastQ);
    end else begin
      grant = rr_pick(req, lastQ);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lastQ <= 3'h5;
    end else if (advance) begin
      for (int k = 0; k < 6; k++) begin
        if (grant[k]) begin
          lastQ <= 3'(k);
        end
      end
    end
  end
endmodule : mdma_arbiter
`default_nettype wire

// ---- bench/mdma_mem_model.sv ----
`default_nettype none
module mdma_mem_model (
  input  wire logic        clk,
  input  wire logic        memRead,
  input  wire logic [15:0] memAddress,
  output logic [15:0]      memReadData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] age;
  initial begin
    age = 2'h0;
    memReadData = 16'h0000;
  end
  // data stands two cycles, then scrambles so a late sample shows up
  always @(posedge clk) begin
    if (memRead === 1'b1) begin
      memReadData <= memAddress ^ 16'h5A5A;
      age <= 2'h2;
    end else begin
      if (age != 2'h2) memReadData <= (age == 2'h1) ? ~memReadData : memReadData + 16'h1357;
      if (age != 2'h0) age <= age - 2'h1;
    end
  end
endmodule : mdma_mem_model
`default_nettype wire

// ---- bench/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, perChannelReloadSelect, processorMemoryMode, romInDataSpace, ramOverlay, pRst;
  logic        cfgWrite, reloadWrite, timerEvent, externalInterruptThree, memRead, memWrite;
  logic        channel4Interrupt, channel5Interrupt;
  logic [1:0]  interruptLineSelect, pSel;
  logic [2:0]  cfgChannel, reloadChannel, cur;
  logic [3:0]  serialPortInterrupt, sharedInterruptLine, pSer;
  logic [5:0]  channelEnable, channelPriority, autoinitializeEnable, doublewordMode, autobufferingMode;
  logic [5:0]  interruptEnableBit, interruptMode, sourceIndexSelect, destinationIndexSelect, pInt;
  logic [5:0]  serialEvent, bitSerialEvent, channelBusy, channelInterrupt;
  logic [7:0]  cfgFrameCount, reloadFrameCount;
  logic [7:0]  seed = 8'h50;
  logic [11:0] sourceModify, destinationModify;
  logic [23:0] syncEventSelect;
  logic [15:0] cfgSourceAddress, cfgDestinationAddress, cfgElementCount, reloadSourceAddress;
  logic [15:0] reloadDestinationAddress, reloadElementCount, elementIndexZero, elementIndexOne;
  logic [15:0] frameIndexZero, frameIndexOne, memReadData, memAddress, memWriteData, lastRd;
  logic [15:0] expR[6][$];
  logic [15:0] expW[6][$];
  int          fails, checksDone, rdCnt[6], intCnt[6], chOrder[$];

  mdma_controller DUT (.*);
  mdma_mem_model mem (.clk, .memRead, .memAddress, .memReadData);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic int step(input int a, input logic [1:0] m, input logic sel, input int last);
    case (m)
      2'h1: return a + 1;
      2'h2: return a - 1;
      2'h3: return a + (last ? (sel ? frameIndexOne : frameIndexZero) : (sel ? elementIndexOne : elementIndexZero));
      default: return a;
    endcase
  endfunction : step

  function automatic logic [3:0] route(input logic [1:0] s, input logic [5:0] ci, input logic [3:0] sp);
    case (s)
      2'h1: return {ci[3:2], sp[1:0]};
      2'h2: return ci[3:0];
      default: return sp;
    endcase
  endfunction : route

  task automatic stop_test;
    if (fails == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
    checksDone++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  // model of one block: element index except on the final half of a frame's last element
  task automatic plan(input int c, input int s, input int d, input int ec, input int fc);
    int nh;
    nh = doublewordMode[c] ? 2 : 1;
    for (int f = 0; f <= fc; f++)
      for (int e = 0; e <= ec; e++)
        for (int h = 0; h < nh; h++) begin
          expR[c].push_back(16'(s));
          expW[c].push_back(16'(d));
          s = step(s, sourceModify[2*c +: 2], sourceIndexSelect[c], e == ec && h == nh - 1);
          d = step(d, destinationModify[2*c +: 2], destinationIndexSelect[c], e == ec && h == nh - 1);
        end
  endtask : plan

  // each channel reads from its own 4K page so reads can be told apart
  task automatic start(input int c, input int ec, input int fc);
    plan(c, c * 4096 + 1024, c * 4096 + 3072, ec, fc);
    cfgWrite = 1'b1;
    cfgChannel = 3'(c);
    cfgSourceAddress = 16'(c * 4096 + 1024);
    cfgDestinationAddress = 16'(c * 4096 + 3072);
    cfgElementCount = 16'(ec);
    cfgFrameCount = 8'(fc);
    @(negedge clk);
    cfgWrite = 1'b0;
    cmp("busy flag", 16'h0001, 16'(channelBusy[c]));
    @(negedge clk);
  endtask : start

  task automatic reload(input int c, input int s, input int d, input int ec, input int fc);
    reloadWrite = 1'b1;
    reloadChannel = 3'(c);
    reloadSourceAddress = 16'(s);
    reloadDestinationAddress = 16'(d);
    reloadElementCount = 16'(ec);
    reloadFrameCount = 8'(fc);
    @(negedge clk);
    reloadWrite = 1'b0;
    @(negedge clk);
  endtask : reload

  // c below 6 waits for n reads of channel c, else for all channels idle
  task automatic wait_for(input int c, input int n);
    int k;
    k = 0;
    repeat (2) @(negedge clk);
    while (c < 6 ? rdCnt[c] < n : channelBusy !== 6'h00) begin
      @(negedge clk);
      k++;
      if (k > 3000) begin
        fails++;
        stop_test();
      end
    end
    if (c == 6) repeat (4) @(negedge clk);
  endtask : wait_for

  task automatic ends(input int c, input int ints);
    cmp("leftover reads", 16'h0000, 16'(expR[c].size()));
    cmp("interrupt count", 16'(ints), 16'(intCnt[c]));
    intCnt[c] = 0;
  endtask : ends

  task automatic pulse(input int k);
    if (k <= 6) serialEvent[k-1] = 1'b1;
    else if (k <= 12) bitSerialEvent[k-7] = 1'b1;
    else if (k == 13) timerEvent = 1'b1;
    else externalInterruptThree = 1'b1;
    @(negedge clk);
    {serialEvent, bitSerialEvent, timerEvent, externalInterruptThree} = '0;
  endtask : pulse

  always @(posedge clk) begin
    pInt <= channelInterrupt;
    pSer <= serialPortInterrupt;
    pSel <= interruptLineSelect;
    pRst <= rst;
  end

  // memory-mode bits wander on purpose: transfers must not care
  always @(negedge clk) begin
    seed = lfsr(seed);
    serialPortInterrupt = seed[3:0];
    {processorMemoryMode, romInDataSpace, ramOverlay} = seed[6:4];
  end

  always @(negedge clk) if (rst === 1'b0) begin
    if (memRead === 1'b1) begin
      cur = memAddress[14:12];
      chOrder.push_back(cur);
      rdCnt[cur]++;
      lastRd = memAddress;
      cmp("read address", expR[cur].size() ? expR[cur].pop_front() : 16'hFFFF, memAddress);
    end
    if (memWrite === 1'b1) begin
      cmp("write address", expW[cur].size() ? expW[cur].pop_front() : 16'hFFFF, memAddress);
      cmp("write data", lastRd ^ 16'h5A5A, memWriteData);
    end
    for (int c = 0; c < 6; c++) if (channelInterrupt[c] === 1'b1) intCnt[c]++;
    if (pRst === 1'b0) begin
      cmp("shared lines", {12'h000, route(pSel, pInt, pSer)}, {12'h000, sharedInterruptLine});
      cmp("own lines", {14'h0000, pInt[5:4]}, {14'h0000, channel5Interrupt, channel4Interrupt});
    end
  end

  initial begin
    {cfgWrite, reloadWrite, timerEvent, externalInterruptThree, perChannelReloadSelect, cfgChannel} = '0;
    {reloadChannel, channelPriority, autoinitializeEnable, doublewordMode, autobufferingMode} = '0;
    {interruptMode, sourceIndexSelect, destinationIndexSelect, serialEvent, bitSerialEvent} = '0;
    {cfgFrameCount, reloadFrameCount, sourceModify, destinationModify, syncEventSelect} = '0;
    {cfgSourceAddress, cfgDestinationAddress, cfgElementCount, reloadSourceAddress} = '0;
    {reloadDestinationAddress, reloadElementCount, elementIndexZero, elementIndexOne} = '0;
    {frameIndexZero, frameIndexOne, interruptLineSelect} = '0;
    {fails, checksDone} = '0;
    channelEnable = 6'h3F;
    interruptEnableBit = 6'h3F;
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int m = 0; m < 6; m++) begin
      sourceModify[1:0] = 2'(m);
      destinationModify[1:0] = 2'(3 - m);
      {sourceIndexSelect[0], destinationIndexSelect[0]} = seed[1:0];
      elementIndexZero = {10'h000, seed[5:0]};
      elementIndexOne = {11'h000, seed[6:2]};
      frameIndexZero = 16'h0021;
      frameIndexOne = {12'h000, seed[3:0]};
      doublewordMode[0] = (m == 3);
      autobufferingMode[0] = (m > 3);
      interruptMode[0] = 1'(m % 2);
      interruptEnableBit[0] = (m != 1);
      interruptLineSelect = 2'(m);
      start(0, 2, 2);
      wait_for(6, 0);
      ends(0, m == 1 ? 0 : (m > 3 ? 1 + m % 2 : (m == 3 ? 3 : 1)));
    end
    {sourceModify, destinationModify} = {12'h555, 12'h555};
    {doublewordMode, autobufferingMode, interruptMode} = '0;
    interruptEnableBit = 6'h3F;
    interruptLineSelect = 2'h1;
    channelEnable = 6'h00;
    channelPriority = 6'h30;
    start(2, 2, 0);
    start(4, 2, 0);
    start(5, 2, 0);
    chOrder.delete();
    channelEnable = 6'h3F;
    wait_for(6, 0);
    cmp("lead channel", 16'h0001, 16'(chOrder[0] > 3));
    for (int k = 0; k < 9; k++)
      cmp("grant order", 16'(k > 5 ? 2 : (k % 2 ? 9 - chOrder[0] : chOrder[0])), 16'(chOrder[k]));
    for (int c = 2; c < 6; c++) if (c != 3) ends(c, 1);
    interruptLineSelect = 2'h2;
    for (int s = 0; s < 2; s++) begin
      perChannelReloadSelect = 1'(s);
      autoinitializeEnable = 6'h02;
      reload(s, 16'h1200, 16'h1600, 1, 1);
      reload(1 - s, 16'h1A00, 16'h1E00, 3, 0);
      rdCnt[1] = 0;
      start(1, 2, 0);
      plan(1, 16'h1200, 16'h1600, 1, 1);
      plan(1, 16'h1200, 16'h1600, 1, 1);
      wait_for(1, 8);
      reload(s, 16'h1300, 16'h1700, 0, 1);
      plan(1, 16'h1300, 16'h1700, 0, 1);
      wait_for(1, 12);
      autoinitializeEnable = 6'h00;
      wait_for(6, 0);
      ends(1, 4);
    end
    interruptEnableBit = 6'h00;
    for (int k = 1; k < 16; k++) begin
      syncEventSelect[15:12] = 4'(k);
      rdCnt[3] = 0;
      start(3, 0, 0);
      pulse(k % 14 + 1);
      repeat (8) @(negedge clk);
      cmp("early reads", 16'h0000, 16'(rdCnt[3]));
      if (k == 15) syncEventSelect[15:12] = 4'h0;
      else pulse(k);
      wait_for(6, 0);
      ends(3, 0);
    end
    stop_test();
  end
endmodule : tb
`default_nettype wire
